// ===== core/swmi_ctrl.sv
// sleep controller and multilevel interrupt prioritizer with apb registers
// Contract
// RULE1: sleep only via sleep instruction from active
// RULE2: five modes, wake set depends on mode
// RULE3: wake runs handler then resumes after sleep
// RULE4: higher pending handlers served first after wake
// RULE5: cpu halted four cycles after wake
// RULE6: all state kept during sleep
// RULE7: reset in sleep restarts from reset vector
// RULE8: enabled interrupt or reset ends sleep
// RULE9: idle stops cpu and nvm clocks only; the code also stops the rtc clock in idle
// RULE10: power-down wakes only on async sources
// RULE11: software gates peripheral clocks, state frozen
// RULE12: peripherals request only while enabled and pending
// RULE13: acknowledge loads handler vector into pc
// RULE14: three priority levels per interrupt
// RULE15: higher level preempts lower running handler
// RULE16: same level, lowest vector first
// RULE17: optional round robin among low level
// RULE18: non-maskable class ignores level enables
// RULE19: vector is peripheral base plus offset
// RULE20: vector table in application or boot section
// RULE21: sleep ignored unless enabled and mode valid
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module swmi_ctrl #(
  parameter int N_SRC = 8,
  parameter logic [7:0] ASYNC_MASK = 8'h03,
  parameter logic [7:0] RTC_MASK = 8'h04
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_SRC-1:0] irq_req,
  input wire logic irq_nmi,
  input wire logic sleep_instr,
  input wire logic cpu_int_ok,
  input wire logic reti,
  input wire logic nvm_busy,
  output logic irq_ack,
  output logic [15:0] irq_vec,
  output logic [2:0] irq_id,
  output logic irq_ack_nmi,
  output logic cpu_halt,
  output logic cpu_clk_en,
  output logic nvm_clk_en,
  output logic rtc_clk_en,
  output logic sleeping,
  output logic [N_SRC-1:0] periph_clk_en
);

  // elaboration check on the source count
  if (N_SRC < 1 || N_SRC > swmi_pkg::NSRC_MAX)
  begin : g_chk
    $error("N_SRC must be 1 to 8");
  end

  // wake masks may only name sources that exist
  if (((ASYNC_MASK | RTC_MASK) >> N_SRC) != 8'h00)
  begin : g_mask_chk
    $error("wake masks name missing sources");
  end

  // every flop of the block lives in this one struct
  swmi_pkg::swmi_st_s s_q; // registered state
  swmi_pkg::swmi_st_s s_d; // next state

  logic [7:0] req; // padded request vector
  logic [2:0] smode; // selected sleep mode
  logic mode_ok; // sleep mode code is defined
  logic [2:0] lvl_en; // level enables low/med/high
  logic [2:0] cur; // highest running level, 0 none
  logic [7:0] req_lv [1:3]; // requests per level
  logic [7:0] wmask; // wake mask of current mode
  logic wake; // qualifying wake source present
  logic gv; // grant valid
  logic [2:0] gid; // granted source
  logic [1:0] glv; // granted level
  logic gnmi; // grant is the nmi
  logic [2:0] ridx; // round robin probe index
  logic setup; // apb setup phase
  logic wr_acc; // apb write access
  logic hit; // mapped address

  assign req = 8'(irq_req); // RULE12
  assign smode = s_q.ctrl[swmi_pkg::CTRL_SMODE_LO +: 3];
  assign lvl_en = s_q.ctrl[swmi_pkg::CTRL_LVLEN_LO +: 3];

  // valid mode decode
  // codes 1, 4 and 5 are reserved; a sleep with them is ignored
  always_comb
  begin
    case (smode)
      swmi_pkg::SM_IDLE,
      swmi_pkg::SM_PDOWN,
      swmi_pkg::SM_PSAVE,
      swmi_pkg::SM_STDBY,
      swmi_pkg::SM_ESTDBY: mode_ok = 1'b1; // RULE2
      default: mode_ok = 1'b0;
    endcase
  end

  // wake sources per mode
  // bit i set: source i may end sleep in this mode
  // undefined codes never reach sleep, so no wake set
  always_comb
  begin
    case (smode)
      swmi_pkg::SM_IDLE: wmask = 8'hff; // RULE9
      swmi_pkg::SM_PDOWN,
      swmi_pkg::SM_STDBY: wmask = ASYNC_MASK; // RULE10
      swmi_pkg::SM_PSAVE,
      swmi_pkg::SM_ESTDBY: wmask = ASYNC_MASK | RTC_MASK; // RULE2
      default: wmask = 8'h00;
    endcase
  end

  // highest level currently in service
  // nmi is not a level here; it blocks all grants on its own
  always_comb
  begin
    if (s_q.act[2])
      cur = 3'h3;
    else if (s_q.act[1])
      cur = 3'h2;
    else if (s_q.act[0])
      cur = 3'h1;
    else
      cur = 3'h0;
  end

  // sort enabled requests by their programmed level
  // a disabled level or level off drops the request
  always_comb
  begin
    for (int l = 1; l <= 3; l++)
    begin
      req_lv[l] = 8'h00;
      for (int i = 0; i < swmi_pkg::NSRC_MAX; i++)
      begin
        if (req[i] && s_q.level[2*i +: 2] == 2'(l) && lvl_en[l-1]) // RULE14
          req_lv[l][i] = 1'b1;
      end
    end
  end

  // arbitration: nmi, then high, med, low above running level
  // only a level above the running one may win, which gives
  // nesting: medium over low, high over both
  always_comb
  begin
    gv = 1'b0;
    gid = 3'h0;
    glv = swmi_pkg::LV_OFF;
    gnmi = 1'b0;
    ridx = 3'h0;
    if (irq_nmi && !s_q.act[3])
    begin
      gv = 1'b1; // RULE18
      gnmi = 1'b1;
    end
    else if (!s_q.act[3])
    begin
      for (int l = 3; l >= 1; l--)
      begin
        if (!gv && 3'(l) > cur && req_lv[l] != 8'h00) // RULE15
        begin
          gv = 1'b1;
          glv = 2'(l);
          if (l == 1 && s_q.ctrl[swmi_pkg::CTRL_RREN])
          begin
            // search starts just past the last low grant
            for (int k = 7; k >= 0; k--)
            begin
              ridx = 3'(s_q.rr_last + 3'(k) + 3'h1);
              if (req_lv[1][ridx])
                gid = ridx; // RULE17
            end
          end
          else
          begin
            // lowest index is lowest vector
            for (int i = 7; i >= 0; i--)
            begin
              if (req_lv[l][i])
                gid = 3'(i); // RULE16
            end
          end
        end
      end
    end
  end

  // wake qualification, always evaluated even while asleep
  // nmi ends only idle sleep; other modes rely on the mask
  assign wake = (irq_nmi && smode == swmi_pkg::SM_IDLE)
              || ((req_lv[1] | req_lv[2] | req_lv[3]) & wmask) != 8'h00; // RULE8

  // apb phase decode and address map
  // unmapped access answers with an error, writes are dropped
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign hit = paddr == swmi_pkg::ADDR_CTRL || paddr == swmi_pkg::ADDR_PWRRED
            || paddr == swmi_pkg::ADDR_LEVEL || paddr == swmi_pkg::ADDR_STATUS;

  // next state of the whole block
  // acknowledge strobes are one cycle wide: cleared by default
  // register writes and reads happen in any sleep state
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.nmi_ack = 1'b0;

    // register writes in the access phase
    // status is read only, so its address falls to default
    if (wr_acc)
    begin
      case (paddr)
        swmi_pkg::ADDR_CTRL: s_d.ctrl = pwdata[8:0];
        swmi_pkg::ADDR_PWRRED: s_d.pwrred = pwdata[7:0]; // RULE11
        swmi_pkg::ADDR_LEVEL: s_d.level = pwdata[15:0]; // RULE14
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end

    // read data captured in the setup phase
    if (setup)
    begin
      case (paddr)
        swmi_pkg::ADDR_CTRL: s_d.prdata = 32'(s_q.ctrl);
        swmi_pkg::ADDR_PWRRED: s_d.prdata = 32'(s_q.pwrred);
        swmi_pkg::ADDR_LEVEL: s_d.prdata = 32'(s_q.level);
        swmi_pkg::ADDR_STATUS: s_d.prdata = 32'({req, 1'b0, s_q.act, s_q.st});
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // handler return drops the highest running level
    // a stray return with nothing running is harmless
    if (reti)
    begin
      if (s_q.act[3])
        s_d.act[3] = 1'b0;
      else if (s_q.act[2])
        s_d.act[2] = 1'b0;
      else if (s_q.act[1])
        s_d.act[1] = 1'b0;
      else
        s_d.act[0] = 1'b0;
    end

    // sleep state machine; it leaves the registers alone, though apb can still write them while asleep
    // sleep wins over a grant in the same cycle; the grant waits
    case (s_q.st)
      swmi_pkg::ST_ACT:
      begin
        // ignored unless enabled with a valid mode
        if (sleep_instr && s_q.ctrl[swmi_pkg::CTRL_SEN] && mode_ok) // RULE21
          s_d.st = swmi_pkg::ST_SLP; // RULE1
        else if (gv && cpu_int_ok && !s_q.ack && !reti)
        begin
          // acknowledge: vector goes out, level marked running
          // the source drops its request on seeing the strobe
          s_d.ack = 1'b1; // RULE13
          s_d.id = gid;
          s_d.nmi_ack = gnmi;
          if (gnmi)
          begin
            s_d.act[3] = 1'b1;
            s_d.vec = swmi_pkg::VEC_NMI;
          end
          else
          begin
            s_d.act[glv-2'h1] = 1'b1; // RULE15
            s_d.vec = swmi_pkg::VEC_PER_BASE
                    + swmi_pkg::VEC_PER_STEP * 16'(gid[2:1])
                    + (gid[0] ? swmi_pkg::VEC_INT_OFS : 16'h0000); // RULE19
            // remember the low winner for the next search
            if (glv == swmi_pkg::LV_LO)
              s_d.rr_last = gid;
          end
          // whole table moves, nmi vector too
          if (s_q.ctrl[swmi_pkg::CTRL_IVSEL])
            s_d.vec = s_d.vec + swmi_pkg::VEC_BOOT_BASE; // RULE20
        end
      end
      swmi_pkg::ST_SLP:
      begin
        // state held as is during sleep
        // the grant path is closed until the halt has run out
        if (wake) // RULE6
        begin
          s_d.st = swmi_pkg::ST_WAKE; // RULE8
          s_d.halt_cnt = swmi_pkg::WAKE_HALT_CYC;
        end
      end
      swmi_pkg::ST_WAKE:
      begin
        // cpu held, then arbitration picks highest pending
        // after the halt the normal grant path runs the handler
        s_d.halt_cnt = s_q.halt_cnt - 3'h1; // RULE5
        if (s_q.halt_cnt == 3'h1)
          s_d.st = swmi_pkg::ST_ACT; // RULE3 RULE4
      end
      default: s_d.st = swmi_pkg::ST_ACT;
    endcase
  end

  // single state register, reset goes to active at reset vector
  // any enabled reset source drives presetn, also from sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.st <= swmi_pkg::ST_ACT; // RULE7
      s_q.halt_cnt <= 3'h0;
      s_q.ctrl <= swmi_pkg::CTRL_RST;
      s_q.pwrred <= swmi_pkg::PWRRED_RST;
      s_q.level <= swmi_pkg::LEVEL_RST;
      s_q.act <= 4'h0;
      s_q.rr_last <= 3'h7;
      s_q.prdata <= 32'h0000_0000;
      s_q.ack <= 1'b0;
      s_q.vec <= 16'h0000;
      s_q.id <= 3'h0;
      s_q.nmi_ack <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // apb answers with no wait states
  // read data was captured in setup, so it stands in access
  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // cpu side
  // all registered, so the vector is stable with the strobe
  assign irq_ack = s_q.ack;
  assign irq_vec = s_q.vec;
  assign irq_id = s_q.id;
  assign irq_ack_nmi = s_q.nmi_ack;
  assign sleeping = s_q.st == swmi_pkg::ST_SLP;
  assign cpu_halt = s_q.st != swmi_pkg::ST_ACT; // RULE5
  assign cpu_clk_en = s_q.st != swmi_pkg::ST_SLP; // RULE9

  // nvm clock runs on while programming finishes
  // so a started write completes before the memory stops
  assign nvm_clk_en = !sleeping || nvm_busy; // RULE9

  // rtc source stops in idle, power-down and standby
  assign rtc_clk_en = !sleeping || smode == swmi_pkg::SM_PSAVE
                   || smode == swmi_pkg::SM_ESTDBY; // RULE10

  // peripheral gating: active and idle only, per mask bit
  // a gated peripheral keeps its state until the bit clears
  always_comb
  begin
    for (int i = 0; i < N_SRC; i++)
      periph_clk_en[i] = !s_q.pwrred[i]
                      && (!sleeping || smode == swmi_pkg::SM_IDLE); // RULE11
  end

endmodule

// ===== dv/swmi_cpu_model.sv
// cpu and interrupt sources on the far side
`timescale 1ns/1ps
module swmi_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_ack,
  input wire logic [2:0] irq_id,
  input wire logic irq_ack_nmi,
  input wire logic [7:0] raise,
  input wire logic [3:0] dly,
  output logic [7:0] irq_req,
  output logic reti
);
  int open_q; // handlers running
  int tmr; // cycles to handler return
  // requests held until taken, handlers return after dly cycles
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_req <= 8'h00;
      reti <= 1'b0;
      open_q <= 0;
      tmr <= 0;
    end
    else
    begin
      irq_req <= (irq_req | raise) & ~((irq_ack && !irq_ack_nmi) ? 8'h01 << irq_id : 8'h00);
      reti <= 1'b0;
      if (irq_ack)
      begin
        open_q <= open_q + 1;
        tmr <= dly;
      end
      else if (open_q > 0 && tmr == 0)
      begin
        reti <= 1'b1;
        open_q <= open_q - 1;
        tmr <= dly;
      end
      else if (tmr > 0)
        tmr <= tmr - 1;
    end
endmodule

// ===== dv/swmi_props.sv
// port checker for the sleep and interrupt block
`timescale 1ns/1ps
module swmi_props #(
  parameter int N_SRC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_instr,
  input wire logic nvm_busy,
  input wire logic irq_ack,
  input wire logic [15:0] irq_vec,
  input wire logic [2:0] irq_id,
  input wire logic irq_ack_nmi,
  input wire logic cpu_halt,
  input wire logic cpu_clk_en,
  input wire logic nvm_clk_en,
  input wire logic sleeping
);
  // one clock domain, one reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_wake_halt: assert property ($fell(sleeping) |-> cpu_halt [*4] ##1 !cpu_halt)
    else $error("halt after wake is not four cycles");
  a_sleep_entry: assert property ($rose(sleeping) |-> $past(sleep_instr))
    else $error("sleep entered without instruction");
  a_sleep_clk: assert property (sleeping |-> !cpu_clk_en && cpu_halt)
    else $error("cpu clock runs in sleep");
  a_nvm_clk: assert property (nvm_clk_en == (!sleeping || nvm_busy))
    else $error("nvm clock enable wrong");
  a_ack_pulse: assert property (irq_ack |=> !irq_ack)
    else $error("acknowledge longer than a cycle");
  a_ack_active: assert property (irq_ack |-> !cpu_halt && !sleeping)
    else $error("acknowledge while halted");
  a_nmi_vec: assert property (irq_ack_nmi |-> irq_ack && (irq_vec & 16'h0fff) == swmi_pkg::VEC_NMI)
    else $error("nmi vector wrong");
  a_vec_sum: assert property (irq_ack && !irq_ack_nmi |->
    (irq_vec & 16'h0fff) == 16'h0004 + {irq_id[2:1], 2'b00} + {irq_id[0], 1'b0})
    else $error("vector is not base plus offset");
endmodule

bind swmi_ctrl swmi_props #(.N_SRC(N_SRC)) swmi_props_inst (.pclk, .presetn, .sleep_instr, .nvm_busy,
  .irq_ack, .irq_vec, .irq_id, .irq_ack_nmi, .cpu_halt, .cpu_clk_en, .nvm_clk_en, .sleeping);

// ===== dv/testbench.sv
// self-checking bench for the sleep and interrupt block
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic [7:0] irq_req, raise = 8'h00, periph_clk_en, m;
  logic [3:0] dly = 4'h1;
  logic [15:0] irq_vec, lv;
  logic [2:0] irq_id;
  logic irq_nmi = 1'b0, sleep_instr = 1'b0, nvm_busy = 1'b0, reti, err;
  logic int_ok = 1'b1; // cpu may take an interrupt
  logic irq_ack, irq_ack_nmi, cpu_halt, cpu_clk_en, nvm_clk_en, rtc_clk_en, sleeping;
  int fails = 0;
  int samples_checked = 0;
  int iv;
  swmi_ctrl swmi_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq_req, .irq_nmi, .sleep_instr, .cpu_int_ok(int_ok), .reti, .nvm_busy, .irq_ack, .irq_vec,
    .irq_id, .irq_ack_nmi, .cpu_halt, .cpu_clk_en, .nvm_clk_en, .rtc_clk_en, .sleeping, .periph_clk_en);
  swmi_cpu_model swmi_cpu_model_inst (.pclk, .presetn, .irq_ack, .irq_id, .irq_ack_nmi, .raise, .dly,
    .irq_req, .reti);
  // free-running clock
  always #2 pclk = ~pclk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // sleep instruction pulse
  task automatic slp();
    @(posedge pclk);
    sleep_instr <= 1'b1;
    @(posedge pclk);
    sleep_instr <= 1'b0;
    @(negedge pclk);
  endtask
  // one acknowledge: wait for it, then check source and vector
  task automatic take(input int id);
    repeat (300) if (irq_ack !== 1'b1) @(negedge pclk);
    chk(irq_ack, 1);
    chk(irq_id, id);
    chk(irq_vec, iv * 16'h1000 + 4 + 4 * (id / 2) + 2 * (id % 2));
    @(negedge pclk);
  endtask
  // model: order by level, then lowest index
  task automatic drain(input logic [7:0] pend);
    int q[$];
    for (int l = 3; l > 0; l--)
      for (int i = 0; i < 8; i++)
        if (pend[i] && lv[2*i +: 2] == l)
          q.push_back(i);
    while (q.size() > 0)
      take(q.pop_front());
  endtask
  // verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #100000;
    fails++;
    test_done();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'hfd02));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 0);
    end
    r = $urandom;
    apb(1'b1, swmi_pkg::ADDR_PWRRED, r);
    apb(1'b0, swmi_pkg::ADDR_PWRRED, 32'h0);
    chk(rd, r[7:0]);
    chk(periph_clk_en, 8'(~r[7:0]));
    apb(1'b1, swmi_pkg::ADDR_PWRRED, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 1);
    $display("registers done");
    for (iv = 0; iv < 2; iv++)
    begin
      lv = 16'($urandom);
      m = 8'($urandom);
      apb(1'b1, swmi_pkg::ADDR_LEVEL, lv);
      apb(1'b1, swmi_pkg::ADDR_CTRL, 32'h1c0 | (iv << 5));
      dly <= iv ? 4'h9 : 4'h1;
      raise <= m;
      @(posedge pclk);
      raise <= 8'h00;
      drain(m);
      // sources left at level off must still be waiting
      @(negedge pclk);
      r = 32'h0;
      for (int i = 0; i < 8; i++)
        r[i] = m[i] && lv[2*i +: 2] == swmi_pkg::LV_OFF;
      chk(irq_req, r);
      lv = 16'hffff;
      apb(1'b1, swmi_pkg::ADDR_LEVEL, lv);
      drain(r[7:0]);
    end
    $display("priority done");
    apb(1'b1, swmi_pkg::ADDR_CTRL, 32'h1e4);
    nvm_busy <= 1'($urandom);
    slp();
    chk(sleeping, 0);
    lv = 16'haaaa;
    apb(1'b1, swmi_pkg::ADDR_LEVEL, lv);
    apb(1'b1, swmi_pkg::ADDR_CTRL, 32'h1e5);
    slp();
    chk({sleeping, cpu_clk_en, rtc_clk_en}, 3'h4);
    @(posedge pclk);
    raise <= 8'h20;
    @(posedge pclk);
    raise <= 8'h00;
    repeat (20) @(negedge pclk);
    chk(sleeping, 1);
    @(posedge pclk);
    raise <= 8'h01;
    @(posedge pclk);
    raise <= 8'h00;
    iv = 1;
    drain(8'h21);
    $display("sleep done");
    iv = 0;
    apb(1'b1, swmi_pkg::ADDR_CTRL, 32'h1c7);
    slp();
    chk({sleeping, rtc_clk_en}, 2'h3);
    @(posedge pclk);
    raise <= 8'h04;
    @(posedge pclk);
    raise <= 8'h00;
    take(2);
    $display("power-save done");
    apb(1'b1, swmi_pkg::ADDR_CTRL, 32'h1c1);
    slp();
    chk({sleeping, periph_clk_en}, 9'h1ff);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({sleeping, cpu_halt}, 0);
    apb(1'b0, swmi_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 0);
    $display("reset in sleep done");
    int_ok <= 1'b0;
    irq_nmi <= 1'b1;
    repeat (5) @(negedge pclk);
    chk(irq_ack, 0);
    @(posedge pclk);
    int_ok <= 1'b1;
    repeat (300) if (irq_ack !== 1'b1) @(negedge pclk);
    chk({irq_ack_nmi, irq_vec}, 17'h10002);
    @(posedge pclk);
    irq_nmi <= 1'b0;
    $display("nmi done");
    apb(1'b1, swmi_pkg::ADDR_LEVEL, 32'h5555);
    apb(1'b1, swmi_pkg::ADDR_CTRL, 32'h1d0);
    raise <= 8'h06;
    @(posedge pclk);
    raise <= 8'h00;
    take(1);
    apb(1'b0, swmi_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0409);
    raise <= 8'h01;
    @(posedge pclk);
    raise <= 8'h00;
    take(2);
    take(0);
    $display("round robin done");
    test_done();
  end
endmodule

// ===== inc/swmi_pkg.sv
// constants, field layouts, states and the state carrier for the sleep/irq block
package swmi_pkg;
  // widest source set the register layout can hold
  localparam int NSRC_MAX = 8;
  // apb register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PWRRED = 12'h004;
  localparam logic [11:0] ADDR_LEVEL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  // control register fields
  localparam int CTRL_SEN = 0;
  localparam int CTRL_SMODE_LO = 1;
  localparam int CTRL_RREN = 4;
  localparam int CTRL_IVSEL = 5;
  localparam int CTRL_LVLEN_LO = 6;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [7:0] PWRRED_RST = 8'h00;
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  // status register fields
  localparam int STAT_ACT_LO = 3;
  localparam int STAT_PEND_LO = 8;
  // sleep mode codes
  localparam logic [2:0] SM_IDLE = 3'h0;
  localparam logic [2:0] SM_PDOWN = 3'h2;
  localparam logic [2:0] SM_PSAVE = 3'h3;
  localparam logic [2:0] SM_STDBY = 3'h6;
  localparam logic [2:0] SM_ESTDBY = 3'h7;
  // per-source level codes
  localparam logic [1:0] LV_OFF = 2'h0;
  localparam logic [1:0] LV_LO = 2'h1;
  localparam logic [1:0] LV_MED = 2'h2;
  localparam logic [1:0] LV_HI = 2'h3;
  // cpu halt after any wake
  localparam logic [2:0] WAKE_HALT_CYC = 3'h4;
  // vector layout, program word addresses
  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_PER_BASE = 16'h0004;
  localparam logic [15:0] VEC_PER_STEP = 16'h0004;
  localparam logic [15:0] VEC_INT_OFS = 16'h0002;
  localparam logic [15:0] VEC_BOOT_BASE = 16'h1000;
  // one-hot sleep controller states
  typedef enum logic [2:0] {
    ST_ACT = 3'b001,
    ST_SLP = 3'b010,
    ST_WAKE = 3'b100
  } swmi_state_e;
  // active handler levels: bit0 low, bit1 med, bit2 high, bit3 nmi
  typedef struct packed {
    swmi_state_e st;
    logic [2:0] halt_cnt;
    logic [8:0] ctrl;
    logic [7:0] pwrred;
    logic [15:0] level;
    logic [3:0] act;
    logic [2:0] rr_last;
    logic [31:0] prdata;
    logic ack;
    logic [15:0] vec;
    logic [2:0] id;
    logic nmi_ack;
  } swmi_st_s;
endpackage
